//--- design/lfs_defines.svh
// constants of the led fault sequencer
`ifndef LFS_DEFINES_SVH
`define LFS_DEFINES_SVH

// ---------------------------------------------------------------
// retry-wait timer
// ---------------------------------------------------------------
`define LFS_CNT_W            16
`define LFS_CNT_RESET        16'h0000
`define LFS_CNT_ONE          16'h0001
`define LFS_SKIP_DEFAULT     16'h03E8

// ---------------------------------------------------------------
// comparator trip points, informative for the analog side
// ---------------------------------------------------------------
`define LFS_CM_SPLIT_V       5
`define LFS_TEMP_STOP_C      165
`define LFS_TEMP_RESUME_C    150

// ---------------------------------------------------------------
// pin levels and reset values
// ---------------------------------------------------------------
`define LFS_PULL_LEVEL       1'b0
`define LFS_FLAG_RESET       1'b0
`define LFS_CMP_RESET        8'h00

`endif

//--- design/lfs_fault_sequencer.sv
// fault detection and hiccup sequencer of a switching led regulator
`timescale 1ns/1ps

`include "lfs_defines.svh"

module lfs_fault_sequencer
  import lfs_pkg::*;
#(
  parameter logic [`LFS_CNT_W-1:0] SKIP_CYCLES = `LFS_SKIP_DEFAULT
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // comparators and fault wire, asynchronous
  input  wire lfs_cmp_t   cmpRaw,
  // internal pwm generator, same clock
  input  wire logic       pwmDimOn,
  // power stage drives
  output lfs_drive_t      drive,
  // fault_report_n open-drain pin
  output logic            faultReportOut,
  output logic            faultReportOe,
  // status
  output logic            faultLineSeenLow,
  output lfs_state_t      seqState
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    lfs_cmp_t   sync1;
    lfs_cmp_t   sync2;
    lfs_state_t state;
    logic       reportHold;
    lfs_drive_t drv;
  } lfs_seq_t;

  lfs_seq_t st_q;
  lfs_seq_t st_d;

  lfs_cmp_t cmp;
  logic     outputUndervoltageDetect;
  logic     ocHighCm;
  logic     ocLowCm;
  logic     reportCond;
  logic     reportClear;
  logic     reportExpired;
  logic     hiccupClear;
  logic     hiccupExpired;
  logic     switching;

  assign cmp = st_q.sync2;

  // ---------------------------------------------------------------
  // fault conditions
  // ---------------------------------------------------------------
  // undervoltage while detection is armed
  // blanked during soft-start and dimming off-phase
  assign outputUndervoltageDetect = cmp.outVoltLow && cmp.ssEnable && pwmDimOn;

  assign ocHighCm = cmp.ocDiff && cmp.cmHigh;

  // low common mode means a hard short path
  // limitation: cmHigh and ocDiff settle through separate synchronisers,
  // so a one-cycle split when both move can start a hiccup early
  assign ocLowCm = cmp.ocDiff && !cmp.cmHigh;

  // a dragged soft-start counts as blanked so the release timer runs
  // this is what makes a tied pin cycle once per retry wait
  assign reportCond = (outputUndervoltageDetect || ocHighCm) && !cmp.ssReset;

  // timer restarts every cycle the condition is present
  assign reportClear = reportCond || !st_q.reportHold;
  assign hiccupClear = (st_q.state != ST_HICCUP);

  // ---------------------------------------------------------------
  // retry-wait timers
  // ---------------------------------------------------------------
  // separate timers: a report hold and a hiccup may overlap
  lfs_retry_timer #(
    .SKIP_CYCLES (SKIP_CYCLES)
  ) reportTimer (
    .clock   (clock),
    .rst_b   (rst_b),
    .clear   (reportClear),
    .expired (reportExpired)
  );

  lfs_retry_timer #(
    .SKIP_CYCLES (SKIP_CYCLES)
  ) hiccupTimer (
    .clock   (clock),
    .rst_b   (rst_b),
    .clear   (hiccupClear),
    .expired (hiccupExpired)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    st_d.sync1 = cmpRaw;
    st_d.sync2 = st_q.sync1;
    switching  = 1'b0;

    // report-only faults set a hold, nothing else
    // hold drops only when the retry wait has run out
    // same release path for high common-mode overcurrent
    // a fault in the cycle of expiry keeps the hold: set wins over release
    if (reportCond) begin
      st_d.reportHold = 1'b1;
    end else if (st_q.reportHold && reportExpired) begin
      st_d.reportHold = 1'b0;
    end

    unique case (st_q.state)
      ST_RUN: begin
        // temperature wins over every other fault
        if (cmp.tempHot) begin
          st_d.state = ST_HOT;
        // entered regardless of the pin wiring
        end else if (ocLowCm) begin
          st_d.state = ST_HICCUP;
        end
      end
      ST_HICCUP: begin
        // restart after one retry wait; a persisting short re-enters here
        // with the short gone, run simply continues
        if (cmp.tempHot) begin
          st_d.state = ST_HOT;
        end else if (hiccupExpired) begin
          st_d.state = ST_RUN;
        end
      end
      ST_HOT: begin
        // hysteresis, only the cool flag ends standby
        if (cmp.tempCool && !cmp.tempHot) begin
          st_d.state = ST_RUN;
        end
      end
      default: begin
        st_d.state = ST_HOT;
      end
    endcase

    // soft-start held in reset stops switching and dimming
    switching = (st_d.state == ST_RUN) && !cmp.ssReset;

    st_d.drv.gateEnable     = switching;
    st_d.drv.dimSwitchDrive = switching && pwmDimOn;
    // standby and hiccup discharge soft-start and compensation
    st_d.drv.ssDischarge    = (st_d.state != ST_RUN);
    st_d.drv.standby        = (st_d.state == ST_HOT);
    // any report, hold, hiccup or standby pulls the pin
    st_d.drv.faultPullOe    = st_d.reportHold || (st_d.state != ST_RUN);
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_q.sync1      <= `LFS_CMP_RESET;
      st_q.sync2      <= `LFS_CMP_RESET;
      st_q.state      <= ST_RUN;
      st_q.reportHold <= `LFS_FLAG_RESET;
      st_q.drv        <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign drive            = st_q.drv;
  // open drain: only ever drives low
  assign faultReportOut   = `LFS_PULL_LEVEL;
  assign faultReportOe    = st_q.drv.faultPullOe;
  assign faultLineSeenLow = cmp.faultLineLow;
  assign seqState         = st_q.state;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_uv_report_low: assert property (
    (outputUndervoltageDetect && !cmp.ssReset) |=> faultReportOe && st_q.reportHold)
    else $error("undervoltage did not pull the fault pin");

  a_uv_blanked_idle: assert property (
    (!cmp.ssEnable && !ocHighCm && !st_q.reportHold && st_q.state == ST_RUN && !cmp.tempHot && !ocLowCm)
      |=> !faultReportOe)
    else $error("undervoltage reported while blanked");

  a_uv_keeps_run: assert property (
    (outputUndervoltageDetect && st_q.state == ST_RUN && !cmp.ssReset && !cmp.tempHot && !ocLowCm)
      |=> drive.gateEnable && !drive.ssDischarge)
    else $error("undervoltage stopped regulation");

  a_release_wait: assert property (
    $fell(st_q.reportHold) |-> $past(reportExpired) && !$past(reportCond))
    else $error("fault hold released before the retry wait");

  a_hold_stays: assert property (
    (st_q.reportHold && !reportExpired) |=> st_q.reportHold && faultReportOe)
    else $error("fault hold dropped early");

  a_ochigh_report: assert property (
    (ocHighCm && !cmp.ssReset && st_q.state == ST_RUN && !cmp.tempHot)
      |=> faultReportOe && drive.gateEnable)
    else $error("high common-mode overcurrent handled wrongly");

  a_ssreset_stop: assert property (
    cmp.ssReset |=> !drive.gateEnable && !drive.dimSwitchDrive)
    else $error("switching with soft-start held in reset");

  a_oclow_shutdown: assert property (
    (st_q.state == ST_RUN && ocLowCm && !cmp.tempHot)
      |=> st_q.state == ST_HICCUP && !drive.gateEnable && !drive.dimSwitchDrive && faultReportOe)
    else $error("low common-mode overcurrent not shut down");

  a_hiccup_hold: assert property (
    (st_q.state == ST_HICCUP && !hiccupExpired && !cmp.tempHot)
      |=> st_q.state == ST_HICCUP && faultReportOe)
    else $error("hiccup ended before the retry wait");

  a_hiccup_restart: assert property (
    (st_q.state == ST_HICCUP && hiccupExpired && !cmp.tempHot) |=> st_q.state == ST_RUN)
    else $error("hiccup did not restart");

  a_hot_standby: assert property (
    cmp.tempHot |=> st_q.state == ST_HOT && drive.standby && faultReportOe && !drive.gateEnable)
    else $error("over-temperature did not enter standby");

  a_hot_stays: assert property (
    (st_q.state == ST_HOT && !cmp.tempCool) |=> st_q.state == ST_HOT)
    else $error("restart before the die cooled");

  a_standby_discharge: assert property (
    drive.standby |-> drive.ssDischarge && !drive.gateEnable && !drive.dimSwitchDrive)
    else $error("standby left drives active");

  a_uv_blank_pwm: assert property (
    (cmp.outVoltLow && cmp.ssEnable && !pwmDimOn && !ocHighCm && !st_q.reportHold
      && st_q.state == ST_RUN && !cmp.tempHot && !ocLowCm) |=> !faultReportOe)
    else $error("undervoltage reported during the dimming off phase");

  a_tied_release: assert property (
    (st_q.reportHold && reportExpired && cmp.ssReset && st_q.state == ST_RUN && !cmp.tempHot && !ocLowCm)
      |=> !faultReportOe)
    else $error("tied soft-start did not release the fault pin after the wait");

  a_restart_release: assert property (
    (st_q.state == ST_HICCUP && hiccupExpired && !cmp.tempHot && !reportCond && !st_q.reportHold)
      |=> !faultReportOe && st_q.state == ST_RUN)
    else $error("fault pin not released at hiccup restart");

  a_oclow_resume: assert property (
    (st_q.state == ST_RUN && !ocLowCm && !cmp.tempHot && !cmp.ssReset)
      |=> st_q.state == ST_RUN && drive.gateEnable)
    else $error("regulation did not resume with the short gone");

  a_hot_exit: assert property (
    (st_q.state == ST_HOT && cmp.tempCool && !cmp.tempHot) |=> st_q.state == ST_RUN && !drive.standby)
    else $error("standby kept after the die cooled");

  a_pin_follows_hold: assert property (
    (st_q.reportHold || st_q.state != ST_RUN) |-> faultReportOe)
    else $error("fault pin released while a hold or shutdown is active");

  a_dim_needs_gate: assert property (
    drive.dimSwitchDrive |-> drive.gateEnable)
    else $error("dimming switch on while switching is stopped");

  // ---------------------------------------------------------------
  // cover points
  // ---------------------------------------------------------------
  c_dim_blank:      cover property (cmp.outVoltLow && cmp.ssEnable && !pwmDimOn);
  c_report_release: cover property ($fell(st_q.reportHold));
  c_hiccup_cycle:   cover property (st_q.state == ST_HICCUP ##1 st_q.state == ST_RUN);
  c_hot_exit:       cover property (st_q.state == ST_HOT ##1 st_q.state == ST_RUN);
  c_tied_pin:       cover property (faultReportOe && cmp.ssReset);

endmodule

//--- design/lfs_pkg.sv
// types of the led fault sequencer
`include "lfs_defines.svh"

package lfs_pkg;

  // -------------------------------------------------------------
  // comparator flags, all level signals from the analog side except the fault wire read back
  // -------------------------------------------------------------
  typedef struct packed {
    logic outVoltLow;      // output_voltage_sense below undervoltage_threshold
    logic ocDiff;          // sense_resistor_top minus bottom above overcurrent_threshold
    logic cmHigh;          // sense common mode above the split level
    logic ssEnable;        // soft-start above detect-enable level
    logic ssReset;         // soft-start below reset level
    logic tempHot;         // die above the shutdown temperature
    logic tempCool;        // die below the resume temperature
    logic faultLineLow;    // fault_report_n wire read back
  } lfs_cmp_t;

  // -------------------------------------------------------------
  // drives toward the power stage and the fault pin
  // -------------------------------------------------------------
  typedef struct packed {
    logic gateEnable;
    logic dimSwitchDrive;
    logic ssDischarge;
    logic standby;
    logic faultPullOe;
  } lfs_drive_t;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_HICCUP = 2'b01,
    ST_HOT    = 2'b10
  } lfs_state_t;

  typedef struct packed {
    logic [`LFS_CNT_W-1:0] count;
  } lfs_timer_t;

endpackage

//--- design/lfs_retry_timer.sv
// retry-wait interval counter
`timescale 1ns/1ps

`include "lfs_defines.svh"

module lfs_retry_timer
  import lfs_pkg::*;
#(
  parameter logic [`LFS_CNT_W-1:0] SKIP_CYCLES = `LFS_SKIP_DEFAULT
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // control
  input  wire logic clear,
  // status
  output logic      expired
);

  lfs_timer_t st_q;
  lfs_timer_t st_d;
  logic [`LFS_CNT_W-1:0] termCount;

  assign termCount = SKIP_CYCLES - `LFS_CNT_ONE;

  // saturating count of the internal clock
  always_comb begin
    st_d = st_q;
    if (clear) begin
      st_d.count = `LFS_CNT_RESET;
    end else if (st_q.count != termCount) begin
      st_d.count = st_q.count + `LFS_CNT_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_q.count <= `LFS_CNT_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign expired = !clear && (st_q.count == termCount);

  a_count_bound: assert property (@(posedge clock) disable iff (!rst_b)
    st_q.count <= termCount) else $error("retry timer ran past its terminal count");

  a_clear_restart: assert property (@(posedge clock) disable iff (!rst_b)
    clear |=> (st_q.count == `LFS_CNT_RESET)) else $error("retry timer not restarted by clear");

endmodule

//--- sim/lfs_fault_sequencer_tb.sv
// self-checking bench of the led fault sequencer
`timescale 1ns/1ps

module lfs_fault_sequencer_tb
  import lfs_pkg::*;
;
  localparam logic [15:0] SKIP = 16'h0008;
  localparam int          LIMIT = 3000;

  logic       clock;
  logic       rst_b;
  lfs_cmp_t   cmpTb;
  lfs_cmp_t   cmpRaw;
  logic       tieToSs;
  logic       pwmDimOn;
  lfs_drive_t drive;
  logic       faultReportOut;
  logic       faultReportOe;
  logic       faultLineSeenLow;
  lfs_state_t seqState;
  logic       faultWire;
  logic [7:0] obsVec;
  logic [7:0] expQ[$];
  logic [7:0] mskQ[$];
  event       chk;
  int         badCount, checked, cycles, hits;

  // {seen, oe, gate, dim, standby, discharge, state}
  assign obsVec = {faultLineSeenLow, faultReportOe, drive.gateEnable, drive.dimSwitchDrive,
                   drive.standby, drive.ssDischarge, seqState};

  lfs_fault_sequencer #(.SKIP_CYCLES(SKIP)) i_dut (
    .clock(clock), .rst_b(rst_b), .cmpRaw(cmpRaw), .pwmDimOn(pwmDimOn), .drive(drive),
    .faultReportOut(faultReportOut), .faultReportOe(faultReportOe),
    .faultLineSeenLow(faultLineSeenLow), .seqState(seqState));

  lfs_host_model i_host (
    .cmpIn(cmpTb), .tieToSs(tieToSs), .faultReportOut(faultReportOut),
    .faultReportOe(faultReportOe), .cmpOut(cmpRaw), .faultWire(faultWire));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic end_sim();
    $display("counts: %0d compared, %0d unexpected", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard, run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      badCount++;
      end_sim();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic expectOut(input logic [7:0] e, input logic [7:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    ->chk;
  endtask

  task automatic chkOut(input logic [7:0] e, input logic [7:0] m);
    checked++;
    if (((obsVec ^ e) & m) !== 8'h00 || drive.faultPullOe !== faultReportOe) begin
      badCount++;
      $display("unexpected at %0t: outputs %b, want %b mask %b", $time, obsVec, e, m);
    end
  endtask

  task automatic chkCount(input int act, input int minv);
    checked++;
    if (act < minv) begin
      badCount++;
      $display("unexpected at %0t: %0d restarts, want at least %0d", $time, act, minv);
    end
  endtask

  // counts gate drops, one per shutdown attempt
  task automatic countDrops(input int n, output int drops);
    logic prev;
    prev  = 1'b1;
    drops = 0;
    repeat (n) begin
      @(negedge clock);
      if (drive.gateEnable === 1'b0 && prev)
        drops++;
      prev = (drive.gateEnable !== 1'b0);
    end
  endtask

  // result watcher: oldest note against present outputs
  initial forever begin
    @(chk);
    chkOut(expQ.pop_front(), mskQ.pop_front());
  end

  initial begin
    cmpTb    = '0;
    tieToSs  = 1'b0;
    pwmDimOn = 1'b1;
    rst_b    = 1'b0;
    badCount = 0;
    checked  = 0;
    void'($urandom(83));
    cyc(16);
    rst_b          = 1'b1;
    cmpTb.ssEnable = 1'b1;
    cyc(10 + ($urandom % 4));
    expectOut(8'h30, 8'hFF);
    cmpTb.outVoltLow = 1'b1;
    cyc(8);
    expectOut(8'hF0, 8'hFF);
    cmpTb.outVoltLow = 1'b0;
    cyc(6);
    expectOut(8'h60, 8'h6F);
    cyc(10);
    expectOut(8'h30, 8'hFF);
    $display("test undervoltage done");
    cmpTb.ssEnable   = 1'b0;
    cmpTb.outVoltLow = 1'b1;
    cyc(12);
    expectOut(8'h30, 8'hFF);
    cmpTb.ssEnable = 1'b1;
    pwmDimOn       = 1'b0;
    cyc(12);
    expectOut(8'h20, 8'hFF);
    // drop the low flag first: pwmDimOn skips the synchronisers
    cmpTb.outVoltLow = 1'b0;
    cyc(3);
    pwmDimOn = 1'b1;
    cyc(13);
    expectOut(8'h30, 8'hFF);
    $display("test blanking done");
    cmpTb.cmHigh = 1'b1;
    cmpTb.ocDiff = 1'b1;
    pwmDimOn     = 1'($urandom);
    cyc(5 + ($urandom % 4));
    expectOut({3'h7, pwmDimOn, 4'h0}, 8'hFF);
    cmpTb.ocDiff = 1'b0;
    cyc(16);
    expectOut(8'h20, 8'hEF);
    $display("test high common mode done");
    cmpTb.cmHigh = 1'b0;
    cmpTb.ocDiff = 1'b1;
    pwmDimOn     = 1'b1;
    cyc(4);
    expectOut(8'h45, 8'h77);
    countDrops(40, hits);
    chkCount(hits, 3);
    cmpTb.ocDiff = 1'b0;
    cyc(30);
    expectOut(8'h20, 8'hEF);
    $display("test low common mode done");
    tieToSs          = 1'b1;
    cmpTb.outVoltLow = 1'b1;
    cyc(6);
    expectOut(8'h40, 8'h74);
    countDrops(60, hits);
    chkCount(hits, 3);
    cmpTb.outVoltLow = 1'b0;
    cyc(30);
    expectOut(8'h20, 8'hEF);
    tieToSs = 1'b0;
    $display("test tied hiccup done");
    cmpTb.tempHot = 1'b1;
    cmpTb.ocDiff  = 1'b1;
    cyc(8);
    expectOut(8'hCE, 8'hFF);
    cmpTb.tempHot = 1'b0;
    cmpTb.ocDiff  = 1'b0;
    cyc(20);
    expectOut(8'h4E, 8'h7F);
    cmpTb.tempCool = 1'b1;
    cyc(24);
    expectOut(8'h20, 8'hEF);
    $display("test thermal done");
    cyc(2);
    end_sim();
  end
endmodule

//--- sim/lfs_host_model.sv
// far-side model: pulled-up fault wire and optional tie to soft-start
`timescale 1ns/1ps

module lfs_host_model
  import lfs_pkg::*;
(
  // comparator levels from the bench
  input  wire lfs_cmp_t cmpIn,
  input  wire logic     tieToSs,
  // fault pin of the device
  input  wire logic     faultReportOut,
  input  wire logic     faultReportOe,
  // resolved levels
  output lfs_cmp_t      cmpOut,
  output logic          faultWire
);
  // pull-up wins unless the device sinks
  assign faultWire = faultReportOe ? faultReportOut : 1'b1;

  always_comb begin
    cmpOut              = cmpIn;
    cmpOut.faultLineLow = ~faultWire;
    // low wire drags soft-start under reset
    cmpOut.ssReset      = cmpIn.ssReset | (tieToSs & ~faultWire);
  end
endmodule
